// ===== iocp_defs.svh
// offsets, field positions, reset values and timing counts of the
// three-phase instantaneous overcurrent block
// assumes a 10 MHz core clock and magnitudes in whole percent of nominal
//
// Function
// - operation setting off, peak or fundamental; off
// - start threshold 20..3000 percent, reset 200
// - trip without added delay above threshold
// - block input forces all trips off
// - doubling input doubles the threshold everywhere
// - one trip flag per phase, own current
// - general trip is OR of phase trips
// - on/off event on every trip change
// - operate under 15 or 25 ms
// - release under 40 or 60 ms
`ifndef IOCP_DEFS_SVH
`define IOCP_DEFS_SVH

// register indices
`define IOCP_ADDR_CTRL 4'h0
`define IOCP_ADDR_START 4'h1
`define IOCP_ADDR_STATE 4'h2
`define IOCP_ADDR_EVT 4'h3
`define IOCP_ADDR_MASK 4'h4

// field layout
`define IOCP_CTRL_MODE_W 2
`define IOCP_START_W 12
`define IOCP_THR_W 13
`define IOCP_MAG_W 16
`define IOCP_EVT_W 8
`define IOCP_EVT_OFF_LSB 4

// settings and reset values
`define IOCP_START_MIN 12'h014
`define IOCP_START_MAX 12'hBB8
`define IOCP_START_RST 12'h0C8
`define IOCP_MASK_RST 8'h00

// reset ratio 0.85 as 85/100
`define IOCP_RATIO_NUM 24'h000055
`define IOCP_RATIO_DEN 24'h000064

// timing
`define IOCP_CLK_KHZ 10000
`define IOCP_RESET_TIME_PEAK_MS 40
`define IOCP_RESET_TIME_FUND_MS 60
`define IOCP_RESET_CYC_PEAK (`IOCP_RESET_TIME_PEAK_MS * `IOCP_CLK_KHZ)
`define IOCP_RESET_CYC_FUND (`IOCP_RESET_TIME_FUND_MS * `IOCP_CLK_KHZ)
`define IOCP_STALE_W 20

`endif

// ===== iocp_front_model.sv
// measurement front end model: peak and fundamental per phase
// assumes the bench sets values; idle lines show inverted values
`timescale 1ns/1ps
module iocp_front_model (
  // clock
  input wire logic core_clk,
  // bench control
  input wire logic run,
  input wire logic slow,
  input wire logic [2:0][15:0] peak_val,
  input wire logic [2:0][15:0] fund_val,
  // magnitudes to the block
  output logic sample_valid_in,
  output logic [2:0][15:0] peak_mag_in,
  output logic [2:0][15:0] fund_mag_in
);
  logic skip_q = 1'b0;
  logic go;
  assign go = run && !(slow && skip_q);
  initial {sample_valid_in, peak_mag_in, fund_mag_in} = '0;
  always @(posedge core_clk) begin
    skip_q <= ~skip_q;
    sample_valid_in <= go;
    peak_mag_in <= go ? peak_val : ~peak_val;
    fund_mag_in <= go ? fund_val : ~fund_val;
  end
endmodule

// ===== iocp_monitor.sv
// port checker for the three-phase overcurrent top
// assumes it is bound into iocp_top, one clock domain
`timescale 1ns/1ps
module iocp_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // sample and block
  input wire logic sample_valid_in,
  input wire logic function_block_in,
  // trips and events
  input wire logic phase1_trip_out,
  input wire logic phase2_trip_out,
  input wire logic phase3_trip_out,
  input wire logic general_trip_out,
  input wire logic [3:0] trip_event_out,
  input wire logic [3:0] trip_event_on_out
);
  logic [2:0] tr;
  logic [3:0] lv;
  assign tr = {phase3_trip_out, phase2_trip_out, phase1_trip_out};
  assign lv = {general_trip_out, tr};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_gen_or: assert property (general_trip_out == |tr)
    else $error("general trip not the phase OR");
  chk_blk_off: assert property (function_block_in [*2] |=> tr == 3'h0)
    else $error("trip while blocked");
  chk_evt_lvl:
    assert property ((trip_event_out & trip_event_on_out) ==
      (lv & ~$past(lv)))
    else $error("event on value wrong");
  chk_evt_chg: assert property (trip_event_out == (lv ^ $past(lv)))
    else $error("event pulse wrong");
  chk_gen_evt:
    assert property (trip_event_out[3] |-> |trip_event_out[2:0])
    else $error("general event alone");
  chk_pick_src:
    assert property (|(tr & ~$past(tr)) |->
      $past(sample_valid_in, 2) && !$past(function_block_in, 2))
    else $error("pickup without sample");
  chk_blk_evt:
    assert property (function_block_in [*4] |-> trip_event_out == 4'h0)
    else $error("event while blocked");
  chk_rd_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside slot");
  cov_trip: cover property ($rose(general_trip_out));
  cov_blk: cover property (function_block_in && general_trip_out);
  cov_off: cover property (trip_event_out[3] && !general_trip_out);
endmodule
bind iocp_top iocp_monitor mon_u (.core_clk(core_clk), .reset_n(reset_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sample_valid_in(sample_valid_in),
  .function_block_in(function_block_in),
  .phase1_trip_out(phase1_trip_out), .phase2_trip_out(phase2_trip_out),
  .phase3_trip_out(phase3_trip_out), .general_trip_out(general_trip_out),
  .trip_event_out(trip_event_out), .trip_event_on_out(trip_event_on_out));

// ===== iocp_phase_decide.sv
// one phase threshold decision with reset-ratio hysteresis
// assumes magnitude and threshold in the same percent unit
`timescale 1ns/1ps
`include "iocp_defs.svh"
module iocp_phase_decide (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // phase carrier
  iocp_phase_if.dec ph
);

  logic trip_q;
  logic trip_d;
  logic [23:0] mag_scaled;
  logic [23:0] thr_scaled;

  // compare 100*mag against 85*threshold for the drop-out level
  assign mag_scaled = 24'(ph.mag) * `IOCP_RATIO_DEN;
  assign thr_scaled = 24'(ph.thr_eff) * `IOCP_RATIO_NUM;

  always_comb begin
    trip_d = trip_q;
    if (!ph.en) begin
      trip_d = 1'b0;
    end else if (ph.strobe) begin
      if (!trip_q) begin
        trip_d = (ph.mag > 16'(ph.thr_eff));
      end else begin
        trip_d = !(mag_scaled < thr_scaled);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= trip_d;
    end
  end

  assign ph.trip = trip_q;

endmodule

// ===== iocp_phase_if.sv
// carrier between the top and one phase decision
// assumes a single clock domain
`timescale 1ns/1ps
interface iocp_phase_if;
  iocp_pkg::iocp_mag_t mag;
  iocp_pkg::iocp_thr_t thr_eff;
  logic en;
  logic strobe;
  logic trip;

  modport src (output mag, output thr_eff, output en, output strobe,
    input trip);
  modport dec (input mag, input thr_eff, input en, input strobe,
    output trip);
endinterface

// ===== iocp_pkg.sv
// types of the three-phase instantaneous overcurrent block
// assumes iocp_defs.svh for numeric constants
package iocp_pkg;

  typedef enum logic [1:0] {
    IOCP_MODE_OFF = 2'h0,
    IOCP_MODE_PEAK = 2'h1,
    IOCP_MODE_FUND = 2'h2
  } iocp_mode_t;

  typedef logic [15:0] iocp_mag_t;
  typedef logic [12:0] iocp_thr_t;

endpackage

// ===== iocp_top.sv
// three-phase instantaneous overcurrent decision with register port
// assumes magnitudes valid on sample_valid_in, all inputs synchronous
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "iocp_defs.svh"
module iocp_top #(
  parameter int unsigned STALE_CYC_PEAK = `IOCP_RESET_CYC_PEAK,
  parameter int unsigned STALE_CYC_FUND = `IOCP_RESET_CYC_FUND
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // measurement front end
  input wire logic sample_valid_in,
  input wire logic [2:0][15:0] peak_mag_in,
  input wire logic [2:0][15:0] fund_mag_in,
  // binary inputs
  input wire logic function_block_in,
  input wire logic threshold_double_in,
  // trip outputs
  output logic phase1_trip_out,
  output logic phase2_trip_out,
  output logic phase3_trip_out,
  output logic general_trip_out,
  // events and interrupt
  output logic [3:0] trip_event_out,
  output logic [3:0] trip_event_on_out,
  output logic irq_out
);

  iocp_pkg::iocp_mode_t mode_q;
  iocp_pkg::iocp_mode_t mode_d;
  logic [11:0] start_q;
  logic [11:0] start_d;
  logic [7:0] evt_q;
  logic [7:0] evt_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [3:0] trip_q;
  logic [3:0] trip_d;
  logic [3:0] chg_q;
  logic [3:0] chg_d;
  logic irq_q;
  logic irq_d;
  logic [19:0] stale_q;
  logic [19:0] stale_d;
  logic stale;
  logic fn_en;
  iocp_pkg::iocp_thr_t thr_eff;
  logic [2:0] phase_trip;
  logic [7:0] new_evt;
  logic [7:0] evt_clr;
  logic [19:0] stale_lim;

  // threshold and enable shared by all phases
  assign thr_eff = threshold_double_in ? {start_q, 1'b0}
                                       : {1'b0, start_q};
  assign fn_en = (mode_q != iocp_pkg::IOCP_MODE_OFF)
               && !function_block_in
               && !stale;

  // lost samples release trips two cycles after the mode's reset count is reached
  assign stale_lim = (mode_q == iocp_pkg::IOCP_MODE_PEAK)
                   ? 20'(STALE_CYC_PEAK) : 20'(STALE_CYC_FUND);
  assign stale = (stale_q >= stale_lim);

  always_comb begin
    stale_d = stale_q;
    if (sample_valid_in) begin
      stale_d = 20'h00000;
    end else if (!stale) begin
      stale_d = stale_q + 20'h00001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      stale_q <= 20'h00000;
    end else begin
      stale_q <= stale_d;
    end
  end

  // per-phase decisions
  for (genvar g = 0; g < 3; g++) begin : gen_phase
    iocp_phase_if ph ();
    assign ph.mag = (mode_q == iocp_pkg::IOCP_MODE_PEAK)
                  ? peak_mag_in[g]
                  : fund_mag_in[g];
    assign ph.thr_eff = thr_eff;
    assign ph.en = fn_en;
    assign ph.strobe = sample_valid_in;
    assign phase_trip[g] = ph.trip;
    iocp_phase_decide u_dec (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .ph(ph.dec)
    );
  end

  // trip outputs and change detection
  always_comb begin
    trip_d = {|phase_trip, phase_trip};
    chg_d = trip_d ^ trip_q;
    new_evt = {chg_q & ~trip_q, chg_q & trip_q};
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      trip_q <= 4'h0;
      chg_q <= 4'h0;
    end else begin
      trip_q <= trip_d;
      chg_q <= chg_d;
    end
  end

  // register file
  always_comb begin
    mode_d = mode_q;
    start_d = start_q;
    mask_d = mask_q;
    evt_clr = 8'h00;
    rdata_d = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        `IOCP_ADDR_CTRL: begin
          if (reg_wdata[1:0] != 2'h3) begin
            mode_d = iocp_pkg::iocp_mode_t'(reg_wdata[1:0]);
          end
        end
        `IOCP_ADDR_START: begin
          if (reg_wdata < 16'(`IOCP_START_MIN)) begin
            start_d = `IOCP_START_MIN;
          end else if (reg_wdata > 16'(`IOCP_START_MAX)) begin
            start_d = `IOCP_START_MAX;
          end else begin
            start_d = reg_wdata[11:0];
          end
        end
        `IOCP_ADDR_EVT: begin
          evt_clr = reg_wdata[7:0];
        end
        `IOCP_ADDR_MASK: begin
          mask_d = reg_wdata[7:0];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `IOCP_ADDR_CTRL: rdata_d = {14'h0000, mode_q};
        `IOCP_ADDR_START: rdata_d = {4'h0, start_q};
        `IOCP_ADDR_STATE: rdata_d = {11'h000, stale, trip_q};
        `IOCP_ADDR_EVT: rdata_d = {8'h00, evt_q};
        `IOCP_ADDR_MASK: rdata_d = {8'h00, mask_q};
        default: rdata_d = 16'h0000;
      endcase
    end
    // a new event wins over a clear in the same cycle
    evt_d = (evt_q & ~evt_clr) | new_evt;
    irq_d = |(evt_d & mask_d);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode_q <= iocp_pkg::IOCP_MODE_OFF;
      start_q <= `IOCP_START_RST;
      mask_q <= `IOCP_MASK_RST;
      evt_q <= 8'h00;
      rdata_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      start_q <= start_d;
      mask_q <= mask_d;
      evt_q <= evt_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign phase1_trip_out = trip_q[0];
  assign phase2_trip_out = trip_q[1];
  assign phase3_trip_out = trip_q[2];
  assign general_trip_out = trip_q[3];
  assign trip_event_out = chg_q;
  assign trip_event_on_out = trip_q;
  assign irq_out = irq_q;

endmodule

// ===== tb_top.sv
// bench for iocp_top: row table, then register, event, release tests
// assumes the front end model feeds samples, checker bound to the top
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [1:0] md;
    logic [15:0] st;
    logic [1:0] db_bk;
    logic [2:0][15:0] m;
    logic [2:0] ex;
  } iocp_tb_row_t;
  logic core_clk, reset_n, reg_wr, reg_rd, run, slow, dbl, blk, vld;
  logic p1, p2, p3, gen, irq;
  logic [3:0] reg_addr, evt, evt_on;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0][15:0] pk, fd, pv, fv;
  int n_mismatch, cmp_count, cyc;
  iocp_tb_row_t rows [8] = '{
    {2'h0, 16'h00C8, 2'h0, 16'h01F4, 16'h01F4, 16'h01F4, 3'h0},
    {2'h1, 16'h00C8, 2'h0, 16'h01F4, 16'h00C8, 16'h00C9, 3'h5},
    {2'h1, 16'h00C8, 2'h0, 16'h00A9, 16'h00AA, 16'h00AB, 3'h1},
    {2'h2, 16'h00C8, 2'h0, 16'h0000, 16'h012C, 16'h0000, 3'h2},
    {2'h2, 16'h00C8, 2'h2, 16'h0191, 16'h012C, 16'h0000, 3'h4},
    {2'h2, 16'h00C8, 2'h3, 16'h0191, 16'h012C, 16'h0000, 3'h0},
    {2'h1, 16'h1388, 2'h0, 16'h0000, 16'h0BB8, 16'h0BB9, 3'h1},
    {2'h3, 16'h000A, 2'h0, 16'h0015, 16'h0014, 16'h0015, 3'h5}};
  iocp_front_model fm_u (.core_clk(core_clk), .run(run), .slow(slow),
    .peak_val(pv), .fund_val(fv), .sample_valid_in(vld),
    .peak_mag_in(pk), .fund_mag_in(fd));
  iocp_top #(.STALE_CYC_PEAK(50), .STALE_CYC_FUND(80)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid_in(vld), .peak_mag_in(pk),
    .fund_mag_in(fd), .function_block_in(blk),
    .threshold_double_in(dbl), .phase1_trip_out(p1),
    .phase2_trip_out(p2), .phase3_trip_out(p3),
    .general_trip_out(gen), .trip_event_out(evt),
    .trip_event_on_out(evt_on), .irq_out(irq));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_trip(input logic [2:0] e);
    cmp({12'h000, gen, p3, p2, p1}, {12'h000, |e, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask
  initial begin
    {reset_n, reg_wr, reg_rd, run, slow, dbl, blk} = '0;
    {reg_addr, reg_wdata, pv, fv} = '0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    run <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h00C8);
    $display("test reset done");
    // magnitudes first, then start, then mode, to avoid false pickups
    foreach (rows[i]) begin
      @(posedge core_clk);
      pv <= rows[i].md == 2'h2 ? 48'h0 : rows[i].m;
      fv <= rows[i].md == 2'h2 ? rows[i].m : 48'h0;
      {dbl, blk} <= rows[i].db_bk;
      slow <= i[0];
      wr(4'h1, rows[i].st);
      wr(4'h0, {14'h0000, rows[i].md});
      tick(6);
      cmp_trip(rows[i].ex);
      $display("test row %0d done", i);
    end
    rd(4'h1, 16'h0014);
    rd(4'h0, 16'h0001);
    rd(4'hF, 16'h0000);
    wr(4'h3, 16'h00FF);
    wr(4'h4, 16'h00FF);
    pv <= 48'h0;
    tick(6);
    rd(4'h3, 16'h00D0);
    cmp({15'h0000, irq}, 16'h0001);
    wr(4'h3, 16'h00FF);
    tick(2);
    cmp({15'h0000, irq}, 16'h0000);
    $display("test events done");
    wr(4'h4, 16'h0000);
    pv <= {32'h0, 16'h0015};
    tick(6);
    cmp({15'h0000, p1}, 16'h0001);
    @(posedge core_clk);
    run <= 1'b0;
    tick(40);
    cmp({15'h0000, p1}, 16'h0001);
    for (int k = 0; k < 30 && p1 === 1'b1; k++) tick(1);
    cmp({15'h0000, p1}, 16'h0000);
    rd(4'h3, 16'h0099);
    cmp({15'h0000, irq}, 16'h0000);
    rd(4'h2, 16'h0010);
    $display("test release done");
    // fundamental mode pickup and its longer release time
    @(posedge core_clk);
    fv <= {32'h0, 16'h0015};
    wr(4'h0, 16'h0002);
    run <= 1'b1;
    tick(6);
    rd(4'h2, 16'h0009);
    @(posedge core_clk);
    run <= 1'b0;
    tick(70);
    cmp({15'h0000, p1}, 16'h0001);
    for (int k = 0; k < 30 && p1 === 1'b1; k++) tick(1);
    cmp({15'h0000, p1}, 16'h0000);
    rd(4'h2, 16'h0010);
    $display("test fundamental release done");
    // reset in mid-run while a trip stands
    @(posedge core_clk);
    run <= 1'b1;
    tick(6);
    cmp_trip(3'h1);
    @(posedge core_clk);
    reset_n <= 1'b0;
    tick(2);
    @(posedge core_clk);
    reset_n <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h00C8);
    rd(4'h3, 16'h0000);
    rd(4'h2, 16'h0000);
    cmp_trip(3'h0);
    $display("test second reset done");
    final_report;
  end
endmodule
